// File: include/csu_cmp_if.sv
// carrier between the sequencer and the algebraic comparator
`timescale 1ns/1ps
`default_nettype none
interface csu_cmp_if;
   logic [35:0] word;
   logic [35:0] lo;
   logic [35:0] hi;
   logic eq_lo;
   logic gt_lo;
   logic gt_hi;
   modport seq (output word, lo, hi, input eq_lo, gt_lo, gt_hi);
   modport cmp (input word, lo, hi, output eq_lo, gt_lo, gt_hi);
endinterface
`default_nettype wire

// File: include/csu_pkg.sv
// shared constants, types and helpers of the compare, skip and search unit
package csu_pkg;
   localparam int unsigned WORD_W = 36;
   // instruction fields
   localparam int OPC_LSB = 30;
   localparam int FN_LSB = 26;
   localparam int AREG_LSB = 22;
   localparam int XREG_LSB = 18;
   localparam int FLAG_H_BIT = 17;
   localparam int FLAG_I_BIT = 16;
   localparam int ADDR_LSB = 0;
   localparam int HALF_SIGN_BIT = 17;
   localparam int INCR_LSB = 18;
   // opcodes
   localparam logic [5:0] OP_TEST_WITHIN_RANGE = 6'h2E;
   localparam logic [5:0] OP_TEST_OUTSIDE_RANGE = 6'h2F;
   localparam logic [5:0] OP_TEST_POSITIVE = 6'h30;
   localparam logic [5:0] OP_TEST_NEGATIVE = 6'h31;
   localparam logic [5:0] OP_SEARCH_EQUAL = 6'h32;
   localparam logic [5:0] OP_SEARCH_UNEQUAL = 6'h33;
   localparam logic [5:0] OP_SEARCH_LESS_OR_EQUAL = 6'h34;
   localparam logic [5:0] OP_SEARCH_GREATER = 6'h35;
   localparam logic [5:0] OP_SEARCH_WITHIN_RANGE = 6'h36;
   localparam logic [5:0] OP_SEARCH_OUTSIDE_RANGE = 6'h37;
   localparam logic [5:0] OP_EXTENDED = 6'h39;
   localparam logic [3:0] FN_DOUBLE_TEST_EQUAL = 4'hF;
   localparam logic [3:0] J_LOWER_HALF = 4'h1;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INSTR_LO = 8'h08;
   localparam logic [7:0] REG_INSTR_HI = 8'h0C;
   localparam logic [7:0] REG_A_LO = 8'h10;
   localparam logic [7:0] REG_A_HI = 8'h14;
   localparam logic [7:0] REG_A1_LO = 8'h18;
   localparam logic [7:0] REG_A1_HI = 8'h1C;
   localparam logic [7:0] REG_X_LO = 8'h20;
   localparam logic [7:0] REG_X_HI = 8'h24;
   localparam logic [7:0] REG_R1_LO = 8'h28;
   localparam logic [7:0] REG_R1_HI = 8'h2C;
   localparam logic [7:0] REG_ADDR = 8'h30;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_SAME_BANK_BIT = 1;
   localparam logic [35:0] RST_WORD = 36'h0_0000_0000;
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_REPEAT_NS = 750;
   localparam int T_SEARCH_ALT_NS = 2250;
   localparam int T_SEARCH_SAME_NS = 3000;
   localparam int T_DTE_SKIP_ALT_NS = 2375;
   localparam int T_DTE_NOSKIP_ALT_NS = 1625;
   localparam int T_DTE_SKIP_SAME_NS = 3125;
   localparam int T_DTE_NOSKIP_SAME_NS = 2375;
   localparam int T_TW_SKIP_ALT_NS = 1750;
   localparam int T_TW_NOSKIP_ALT_NS = 1000;
   localparam int T_TW_SKIP_SAME_NS = 2500;
   localparam int T_TW_NOSKIP_SAME_NS = 1750;
   localparam int T_TST_SKIP_ALT_NS = 1500;
   localparam int T_TST_NOSKIP_ALT_NS = 750;
   localparam int T_TST_SKIP_SAME_NS = 2250;
   localparam int T_TST_NOSKIP_SAME_NS = 1500;
   localparam int P1 = CLK_PERIOD_NS - 1;
   localparam logic [31:0] C_REPEAT = 32'((T_REPEAT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_SEARCH_ALT = 32'((T_SEARCH_ALT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_SEARCH_SAME = 32'((T_SEARCH_SAME_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_DTE_SKIP_ALT = 32'((T_DTE_SKIP_ALT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_DTE_NOSKIP_ALT = 32'((T_DTE_NOSKIP_ALT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_DTE_SKIP_SAME = 32'((T_DTE_SKIP_SAME_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_DTE_NOSKIP_SAME = 32'((T_DTE_NOSKIP_SAME_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TW_SKIP_ALT = 32'((T_TW_SKIP_ALT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TW_NOSKIP_ALT = 32'((T_TW_NOSKIP_ALT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TW_SKIP_SAME = 32'((T_TW_SKIP_SAME_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TW_NOSKIP_SAME = 32'((T_TW_NOSKIP_SAME_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TST_SKIP_ALT = 32'((T_TST_SKIP_ALT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TST_NOSKIP_ALT = 32'((T_TST_NOSKIP_ALT_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TST_SKIP_SAME = 32'((T_TST_SKIP_SAME_NS + P1) / CLK_PERIOD_NS);
   localparam logic [31:0] C_TST_NOSKIP_SAME = 32'((T_TST_NOSKIP_SAME_NS + P1) / CLK_PERIOD_NS);

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_FETCH = 4'h2,
      ST_EVAL = 4'h4,
      ST_WAIT = 4'h8
   } csu_state_t;

   // ones' complement word to two's complement value, both zeros map to 0
   function automatic logic signed [36:0] oc_val(input logic [35:0] w);
      logic signed [36:0] mag;
      mag = $signed({2'b00, (w[35] ? ~w[34:0] : w[34:0])});
      return w[35] ? -mag : mag;
   endfunction
endpackage

// File: verif/csu_storage_model.sv
// storage bank model answering word reads after a short wait
`timescale 1ns/1ps
`default_nettype none
module csu_storage_model (
   input wire logic clock_i,
   input wire logic req_i,
   input wire logic [15:0] addr_i,
   output logic ack_o,
   output logic [35:0] rdata_o
);
   logic [35:0] mem [0:255];
   int wait_n = 0;
   initial begin
      ack_o = 1'b0;
      rdata_o = 36'h0_0000_0000;
   end
   // outside an answer the data lines toggle so stale words never match
   always @(posedge clock_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
         wait_n <= (wait_n == 2) ? 0 : wait_n + 1;
         if (wait_n == 2) begin
            ack_o <= 1'b1;
            rdata_o <= mem[addr_i[7:0]];
         end
      end
   end
endmodule
`default_nettype wire

// File: verif/test_csu_unit.sv
// self-checking bench of the compare, skip and search unit
`timescale 1ns/1ps
`default_nettype none
module test_csu_unit;
   import csu_pkg::*;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic pready, pslverr, err, mem_req, mem_ack, busy, skip;
   logic [15:0] mem_addr;
   logic [35:0] mem_rdata;
   int n_errors = 0, n_checks = 0, cyc = 0;
   always #2.5 clock_i = ~clock_i;
   csu_unit u_dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .mem_req_o(mem_req), .mem_addr_o(mem_addr),
      .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack), .busy_o(busy), .skip_o(skip));
   csu_storage_model u_mem (.clock_i(clock_i), .req_i(mem_req), .addr_i(mem_addr),
      .ack_o(mem_ack), .rdata_o(mem_rdata));
   function automatic logic [35:0] oc(input int i);
      return (i < 0) ? ~36'(-i) : 36'(i);
   endfunction
   function automatic logic [31:0] sa(input int k, input logic s);
      return (s ? C_SEARCH_SAME : C_SEARCH_ALT) + C_REPEAT * 32'(k);
   endfunction
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1) @(posedge clock_i);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic w36(input logic [7:0] a, input logic [35:0] v);
      apb(1'b1, a, v[31:0]);
      apb(1'b1, a + 8'h04, {28'h000_0000, v[35:32]});
   endtask
   task automatic fill(input int f);
      for (int i = 90; i < 110; i++) u_mem.mem[i] = oc(f);
   endtask
   task automatic run(input logic [5:0] op, input logic [3:0] fn, input int a, input int a1,
         input int inc, input int r1, input logic same, input logic sk, input logic [31:0] cy);
      int n;
      w36(REG_INSTR_LO, {op, fn, 4'hA, 4'h0, 2'b00, 16'h0064});
      w36(REG_A_LO, oc(a));
      w36(REG_A1_LO, oc(a1));
      w36(REG_X_LO, oc(inc) << 18);
      w36(REG_R1_LO, oc(r1));
      apb(1'b1, REG_CTRL, {30'h0000_0000, same, 1'b1});
      n = 0;
      do begin
         @(posedge clock_i);
         #1;
         n++;
      end while (busy === 1'b1 && n < 9000);
      chk(36'(skip), 36'(sk));
      chk(36'(n), 36'(cy));
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(36'(q), {32'h0000_0000, cy == 32'h0000_0001, sk, 2'b10});
      $display("test of opcode %h ended", op);
   endtask
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(posedge clock_i);
      reset_i <= 1'b0;
      apb(1'b0, 8'hFC, 32'h0000_0000);
      chk(36'(err), 36'h0_0000_0001);
      chk(36'(q), 36'h0_0000_0000);
      fill(10);
      run(OP_TEST_WITHIN_RANGE, 4'h0, 5, 10, 0, 0, 0, 1, C_TW_SKIP_ALT);
      fill(5);
      run(OP_TEST_WITHIN_RANGE, 4'h0, 5, 10, 0, 0, 0, 0, C_TW_NOSKIP_ALT);
      run(OP_TEST_OUTSIDE_RANGE, 4'h0, 5, 10, 0, 0, 0, 1, C_TST_SKIP_ALT);
      fill(7);
      run(OP_TEST_OUTSIDE_RANGE, 4'h0, 5, 10, 0, 0, 0, 0, C_TST_NOSKIP_ALT);
      fill(-1);
      run(OP_TEST_POSITIVE, 4'h0, -7, 0, 0, 0, 0, 0, C_TST_NOSKIP_ALT);
      fill(5);
      run(OP_TEST_POSITIVE, 4'h0, 7, 0, 0, 0, 1, 1, C_TST_SKIP_SAME);
      u_mem.mem[100] = 36'hF_FFFF_FFFF;
      run(OP_TEST_NEGATIVE, 4'h0, 0, 0, 0, 0, 1, 1, C_TST_SKIP_SAME);
      u_mem.mem[100] = 36'h8_0000_0000;
      run(OP_TEST_POSITIVE, J_LOWER_HALF, 0, 0, 0, 0, 0, 1, C_TST_SKIP_ALT);
      run(6'h00, 4'h0, 0, 0, 0, 0, 0, 0, 32'h0000_0001);
      fill(3);
      u_mem.mem[101] = oc(-4);
      run(OP_EXTENDED, FN_DOUBLE_TEST_EQUAL, 3, -4, 0, 0, 0, 1, C_DTE_SKIP_ALT);
      run(OP_EXTENDED, FN_DOUBLE_TEST_EQUAL, 3, -4, 0, 0, 1, 1, C_DTE_SKIP_SAME);
      u_mem.mem[101] = oc(4);
      run(OP_EXTENDED, FN_DOUBLE_TEST_EQUAL, 3, -4, 0, 0, 0, 0, C_DTE_NOSKIP_ALT);
      fill(0);
      u_mem.mem[101] = oc(7);
      u_mem.mem[104] = oc(7);
      run(OP_SEARCH_EQUAL, 4'h0, 7, 0, 2, 5, 0, 1, sa(3, 0));
      fill(0);
      run(OP_SEARCH_EQUAL, 4'h0, 7, 0, 1, 3, 1, 0, sa(3, 1));
      u_mem.mem[102] = 36'hF_FFFF_FFFF;
      u_mem.mem[103] = oc(1);
      run(OP_SEARCH_UNEQUAL, 4'h0, 0, 0, 1, 6, 0, 1, sa(4, 0));
      fill(9);
      u_mem.mem[98] = oc(-5);
      u_mem.mem[101] = oc(0);
      run(OP_SEARCH_LESS_OR_EQUAL, 4'h0, 3, 0, -1, 5, 0, 1, sa(3, 0));
      fill(-3);
      u_mem.mem[102] = 36'hF_FFFF_FFFF;
      run(OP_SEARCH_GREATER, 4'h0, -2, 0, 1, 5, 0, 1, sa(3, 0));
      u_mem.mem[100] = oc(5);
      u_mem.mem[101] = oc(11);
      u_mem.mem[102] = oc(10);
      run(OP_SEARCH_WITHIN_RANGE, 4'h0, 5, 10, 1, 5, 0, 1, sa(3, 0));
      fill(7);
      u_mem.mem[101] = oc(10);
      u_mem.mem[102] = oc(11);
      run(OP_SEARCH_OUTSIDE_RANGE, 4'h0, 5, 10, 1, 5, 0, 1, sa(3, 0));
      complete_run();
   end
endmodule
`default_nettype wire

// File: verilog/csu_compare.sv
// signed ones' complement comparator of a word against two bounds
`timescale 1ns/1ps
`default_nettype none
module csu_compare
   import csu_pkg::*;
(
   csu_cmp_if.cmp cmp_io
);
   logic signed [36:0] w_val;
   logic signed [36:0] lo_val;
   logic signed [36:0] hi_val;

   assign w_val = oc_val(cmp_io.word);
   assign lo_val = oc_val(cmp_io.lo);
   assign hi_val = oc_val(cmp_io.hi);
   assign cmp_io.eq_lo = (w_val == lo_val);
   assign cmp_io.gt_lo = (w_val > lo_val);
   assign cmp_io.gt_hi = (w_val > hi_val);
endmodule
`default_nettype wire

// File: verilog/csu_unit.sv
// compare, skip and search execution unit with apb register access
// How it works
// - within-range test skips when A < word <= A+1
// - outside-range test skips when word <= A or word > A+1
// - positive test skips when selected word sign bit is zero
// - negative test skips when selected word sign bit is one
// - sign tests never look at the arithmetic register field
// - double test compares U,U+1 with A,A+1, skips when both equal
// - double test busy time depends on skip and bank choice
// - searches take base time plus one repeat time per word examined
// - search for equal stops and skips at first equal word
// - search that never meets its condition ends without skip
// - search for unequal stops and skips at first differing word
// - search for less-or-equal skips on word <= A
// - search for greater skips on word > A
// - search within range skips on A < word <= A+1
// - search outside range skips on word <= A or word > A+1
// - each repeat adds the index upper-half increment to the address
// - a negative increment walks the addresses downward
// - instruction fields decoded at their fixed bit positions
// - repeat count drops each repeat; zero ends the search
`timescale 1ns/1ps
`default_nettype none
module csu_unit
   import csu_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic mem_req_o,
   output logic [15:0] mem_addr_o,
   input wire logic [35:0] mem_rdata_i,
   input wire logic mem_ack_i,
   output logic busy_o,
   output logic skip_o
);
   csu_cmp_if cmp_bus();
   csu_state_t state;
   logic [35:0] instr;
   logic [35:0] a_reg;
   logic [35:0] a1_reg;
   logic [35:0] x_reg;
   logic [35:0] r1_reg;
   logic [35:0] cur;
   logic same_bank;
   logic done;
   logic bad;
   logic second;
   logic eq0;
   logic [31:0] elapsed;
   logic [31:0] required;
   logic [31:0] reps;
   logic [31:0] prdata;
   logic pslverr;
   logic apb_wr;
   logic start;
   logic busy;
   logic [5:0] f_op;
   logic [3:0] f_fn;
   logic [3:0] f_j;
   logic [15:0] f_u;
   logic is_test;
   logic is_search;
   logic is_dte;
   logic hit;
   logic [15:0] step;
   logic [17:0] next_xlo;
   logic [31:0] search_base;

   // merge a 32-bit bus half into a 36-bit word
   function automatic logic [35:0] put36(input logic [35:0] old, input logic hi,
                                         input logic [31:0] d);
      return hi ? {d[3:0], old[31:0]} : {old[35:32], d};
   endfunction

   // sign of whole word, or of the lower half when that part is selected
   function automatic logic sign_pick(input logic [35:0] w, input logic [3:0] j);
      return (j == J_LOWER_HALF) ? w[HALF_SIGN_BIT] : w[35];
   endfunction

   // ones' complement 18-bit increment to a 16-bit address step
   function automatic logic [15:0] oc_step(input logic [17:0] inc);
      logic [17:0] mag;
      mag = inc[17] ? ~inc : inc;
      return inc[17] ? (16'h0000 - mag[15:0]) : mag[15:0];
   endfunction

   // busy time of the single-word and double-word tests
   function automatic logic [31:0] test_cycles(input logic [5:0] op, input logic double_test_equal,
                                               input logic sk, input logic same);
      logic [31:0] t;
      t = same ? (sk ? C_TST_SKIP_SAME : C_TST_NOSKIP_SAME)
               : (sk ? C_TST_SKIP_ALT : C_TST_NOSKIP_ALT);
      if (double_test_equal) begin
         t = same ? (sk ? C_DTE_SKIP_SAME : C_DTE_NOSKIP_SAME)
                  : (sk ? C_DTE_SKIP_ALT : C_DTE_NOSKIP_ALT);
      end else if (op == OP_TEST_WITHIN_RANGE) begin
         t = same ? (sk ? C_TW_SKIP_SAME : C_TW_NOSKIP_SAME)
                  : (sk ? C_TW_SKIP_ALT : C_TW_NOSKIP_ALT);
      end
      return t;
   endfunction

   // instruction decode
   assign f_op = instr[OPC_LSB +: 6];
   assign f_fn = instr[FN_LSB +: 4];
   assign f_j = instr[26 +: 4] & 4'hF;
   assign f_u = instr[ADDR_LSB +: 16];
   assign is_test = (f_op == OP_TEST_WITHIN_RANGE) || (f_op == OP_TEST_OUTSIDE_RANGE) ||
                    (f_op == OP_TEST_POSITIVE) || (f_op == OP_TEST_NEGATIVE);
   assign is_search = (f_op >= OP_SEARCH_EQUAL) && (f_op <= OP_SEARCH_OUTSIDE_RANGE);
   assign is_dte = (f_op == OP_EXTENDED) && (f_fn == FN_DOUBLE_TEST_EQUAL);
   assign busy = (state != ST_IDLE);
   assign search_base = same_bank ? C_SEARCH_SAME : C_SEARCH_ALT;
   assign step = oc_step(x_reg[INCR_LSB +: 18]);
   assign next_xlo = 18'(x_reg[17:0] + {{2{step[15]}}, step});

   // comparator hookup: second double-test word meets A+1
   assign cmp_bus.word = cur;
   assign cmp_bus.lo = second ? a1_reg : a_reg;
   assign cmp_bus.hi = a1_reg;

   csu_compare u_compare (
      .cmp_io(cmp_bus)
   );

   // condition met by the current word
   always_comb begin
      case (f_op)
         OP_TEST_WITHIN_RANGE: hit = cmp_bus.gt_lo & ~cmp_bus.gt_hi;
         OP_TEST_OUTSIDE_RANGE: hit = ~cmp_bus.gt_lo | cmp_bus.gt_hi;
         OP_TEST_POSITIVE: hit = ~sign_pick(cur, f_j);
         OP_TEST_NEGATIVE: hit = sign_pick(cur, f_j);
         OP_SEARCH_EQUAL: hit = cmp_bus.eq_lo;
         OP_SEARCH_UNEQUAL: hit = ~cmp_bus.eq_lo;
         OP_SEARCH_LESS_OR_EQUAL: hit = ~cmp_bus.gt_lo;
         OP_SEARCH_GREATER: hit = cmp_bus.gt_lo;
         OP_SEARCH_WITHIN_RANGE: hit = cmp_bus.gt_lo & ~cmp_bus.gt_hi;
         OP_SEARCH_OUTSIDE_RANGE: hit = ~cmp_bus.gt_lo | cmp_bus.gt_hi;
         default: hit = 1'b0;
      endcase
   end

   // apb slave, zero wait states
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign start = apb_wr & (paddr_i == REG_CTRL) & pwdata_i[CTRL_START_BIT] & ~busy;
   assign pready_o = 1'b1;
   assign prdata_o = prdata;
   assign pslverr_o = pslverr;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel_i & ~penable_i) begin
         pslverr <= 1'b0;
         case (paddr_i)
            REG_CTRL: prdata <= {30'h0000_0000, same_bank, 1'b0};
            REG_STATUS: prdata <= {28'h000_0000, bad, skip_o, done, busy};
            REG_INSTR_LO: prdata <= instr[31:0];
            REG_INSTR_HI: prdata <= {28'h000_0000, instr[35:32]};
            REG_A_LO: prdata <= a_reg[31:0];
            REG_A_HI: prdata <= {28'h000_0000, a_reg[35:32]};
            REG_A1_LO: prdata <= a1_reg[31:0];
            REG_A1_HI: prdata <= {28'h000_0000, a1_reg[35:32]};
            REG_X_LO: prdata <= x_reg[31:0];
            REG_X_HI: prdata <= {28'h000_0000, x_reg[35:32]};
            REG_R1_LO: prdata <= r1_reg[31:0];
            REG_R1_HI: prdata <= {28'h000_0000, r1_reg[35:32]};
            REG_ADDR: prdata <= {16'h0000, mem_addr_o};
            default: begin
               prdata <= 32'h0000_0000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

   // operand registers, frozen while an instruction runs
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         instr <= RST_WORD;
         a_reg <= RST_WORD;
         a1_reg <= RST_WORD;
         same_bank <= 1'b0;
      end else if (apb_wr & ~busy) begin
         case (paddr_i)
            REG_CTRL: same_bank <= pwdata_i[CTRL_SAME_BANK_BIT];
            REG_INSTR_LO: instr <= put36(instr, 1'b0, pwdata_i);
            REG_INSTR_HI: instr <= put36(instr, 1'b1, pwdata_i);
            REG_A_LO: a_reg <= put36(a_reg, 1'b0, pwdata_i);
            REG_A_HI: a_reg <= put36(a_reg, 1'b1, pwdata_i);
            REG_A1_LO: a1_reg <= put36(a1_reg, 1'b0, pwdata_i);
            REG_A1_HI: a1_reg <= put36(a1_reg, 1'b1, pwdata_i);
            default: begin
            end
         endcase
      end
   end

   // sequencer with index and repeat count
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         x_reg <= RST_WORD;
         r1_reg <= RST_WORD;
         cur <= RST_WORD;
         mem_req_o <= 1'b0;
         mem_addr_o <= 16'h0000;
         skip_o <= 1'b0;
         done <= 1'b0;
         bad <= 1'b0;
         second <= 1'b0;
         eq0 <= 1'b0;
         elapsed <= 32'h0000_0000;
         required <= 32'h0000_0000;
         reps <= 32'h0000_0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  elapsed <= 32'h0000_0000;
                  required <= 32'h0000_0001;
                  reps <= 32'h0000_0000;
                  skip_o <= 1'b0;
                  done <= 1'b0;
                  bad <= 1'b0;
                  second <= 1'b0;
                  mem_addr_o <= 16'(f_u + x_reg[15:0]);
                  if (!(is_test || is_search || is_dte)) begin
                     bad <= 1'b1;
                     state <= ST_WAIT;
                  end else if (is_search && (r1_reg == RST_WORD)) begin
                     required <= search_base;
                     state <= ST_WAIT;
                  end else begin
                     mem_req_o <= 1'b1;
                     state <= ST_FETCH;
                  end
               end else if (apb_wr) begin
                  case (paddr_i)
                     REG_X_LO: x_reg <= put36(x_reg, 1'b0, pwdata_i);
                     REG_X_HI: x_reg <= put36(x_reg, 1'b1, pwdata_i);
                     REG_R1_LO: r1_reg <= put36(r1_reg, 1'b0, pwdata_i);
                     REG_R1_HI: r1_reg <= put36(r1_reg, 1'b1, pwdata_i);
                     default: begin
                     end
                  endcase
               end
            end
            ST_FETCH: begin
               elapsed <= elapsed + 32'h0000_0001;
               if (mem_ack_i) begin
                  cur <= mem_rdata_i;
                  mem_req_o <= 1'b0;
                  state <= ST_EVAL;
               end
            end
            ST_EVAL: begin
               elapsed <= elapsed + 32'h0000_0001;
               state <= ST_WAIT;
               if (is_dte) begin
                  if (!second) begin
                     eq0 <= cmp_bus.eq_lo;
                     second <= 1'b1;
                     mem_addr_o <= mem_addr_o + 16'h0001;
                     mem_req_o <= 1'b1;
                     state <= ST_FETCH;
                  end else begin
                     skip_o <= eq0 & cmp_bus.eq_lo;
                     required <= test_cycles(f_op, 1'b1, eq0 & cmp_bus.eq_lo, same_bank);
                  end
               end else if (is_test) begin
                  skip_o <= hit;
                  required <= test_cycles(f_op, 1'b0, hit, same_bank);
               end else begin
                  reps <= reps + 32'h0000_0001;
                  r1_reg <= r1_reg - 36'h0_0000_0001;
                  x_reg[17:0] <= next_xlo;
                  if (hit || (r1_reg == 36'h0_0000_0001)) begin
                     skip_o <= hit;
                     required <= 32'(search_base + (reps + 32'h0000_0001) * C_REPEAT);
                  end else begin
                     mem_addr_o <= 16'(f_u + next_xlo[15:0]);
                     mem_req_o <= 1'b1;
                     state <= ST_FETCH;
                  end
               end
            end
            ST_WAIT: begin
               if (elapsed + 32'h0000_0001 >= required) begin
                  done <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  elapsed <= elapsed + 32'h0000_0001;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign busy_o = busy;

   // checks
   logic eval_test;
   logic eval_search;
   assign eval_test = (state == ST_EVAL) && is_test;
   assign eval_search = (state == ST_EVAL) && is_search;

   property p_within;
      @(posedge clock_i) disable iff (reset_i)
      (eval_test && f_op == OP_TEST_WITHIN_RANGE) |=> skip_o ==
         ((oc_val($past(cur)) > oc_val(a_reg)) && (oc_val($past(cur)) <= oc_val(a1_reg)));
   endproperty
   a_within: assert property (p_within) else $error("within test skip wrong");

   property p_outside;
      @(posedge clock_i) disable iff (reset_i)
      (eval_test && f_op == OP_TEST_OUTSIDE_RANGE) |=> skip_o ==
         ((oc_val($past(cur)) <= oc_val(a_reg)) || (oc_val($past(cur)) > oc_val(a1_reg)));
   endproperty
   a_outside: assert property (p_outside) else $error("outside test skip wrong");

   property p_sign;
      @(posedge clock_i) disable iff (reset_i)
      (eval_test && (f_op == OP_TEST_POSITIVE || f_op == OP_TEST_NEGATIVE)) |=>
         skip_o == (sign_pick($past(cur), f_j) == (f_op == OP_TEST_NEGATIVE));
   endproperty
   a_sign: assert property (p_sign) else $error("sign test skip wrong");

   property p_dte_time;
      @(posedge clock_i) disable iff (reset_i)
      ($fell(busy) && is_dte) |-> ($past(elapsed) + 32'h0000_0001) ==
         (same_bank ? (skip_o ? C_DTE_SKIP_SAME : C_DTE_NOSKIP_SAME)
                    : (skip_o ? C_DTE_SKIP_ALT : C_DTE_NOSKIP_ALT));
   endproperty
   a_dte_time: assert property (p_dte_time) else $error("double test time wrong");

   property p_search_time;
      @(posedge clock_i) disable iff (reset_i)
      ($fell(busy) && is_search) |->
         ($past(elapsed) + 32'h0000_0001) >= 32'(search_base + reps * C_REPEAT);
   endproperty
   a_search_time: assert property (p_search_time) else $error("search time short");

   property p_stop_on_hit;
      @(posedge clock_i) disable iff (reset_i)
      (eval_search && hit) |=> (state == ST_WAIT) && skip_o && !mem_req_o;
   endproperty
   a_stop_on_hit: assert property (p_stop_on_hit) else $error("search did not stop");

   property p_exhaust;
      @(posedge clock_i) disable iff (reset_i)
      (eval_search && !hit && r1_reg == 36'h0_0000_0001) |=>
         (state == ST_WAIT) && !skip_o && (r1_reg == RST_WORD);
   endproperty
   a_exhaust: assert property (p_exhaust) else $error("exhausted search wrong");

   property p_step;
      @(posedge clock_i) disable iff (reset_i)
      (eval_search && !hit && r1_reg != 36'h0_0000_0001) |=>
         mem_req_o && (mem_addr_o == 16'(f_u + $past(next_xlo[15:0])));
   endproperty
   a_step: assert property (p_step) else $error("search address step wrong");

   property p_count;
      @(posedge clock_i) disable iff (reset_i)
      eval_search |=> r1_reg == $past(r1_reg) - 36'h0_0000_0001;
   endproperty
   a_count: assert property (p_count) else $error("repeat count not decremented");

   property p_finish;
      @(posedge clock_i) disable iff (reset_i)
      (state == ST_WAIT && elapsed + 32'h0000_0001 >= required) |=> !busy && done;
   endproperty
   a_finish: assert property (p_finish) else $error("finish not flagged");

   c_search_skip: cover property (@(posedge clock_i) disable iff (reset_i)
      $fell(busy) && is_search && skip_o);
   c_search_miss: cover property (@(posedge clock_i) disable iff (reset_i)
      $fell(busy) && is_search && !skip_o && reps > 32'h0000_0001);
   c_dte_skip: cover property (@(posedge clock_i) disable iff (reset_i)
      $fell(busy) && is_dte && skip_o);
   c_descend: cover property (@(posedge clock_i) disable iff (reset_i)
      eval_search && x_reg[35]);
endmodule
`default_nettype wire
